// ===== dgw_config_bank.sv
// Receive-path gain, clock recovery and wake timer configuration bank.
// Assumes a host-side serial port that presents address, write strobe and data
// on this clock, and a sync-found level from the demodulator on the same clock.
// Operation
// - Pre-sync integral gain is (setting+1) times base integral gain.
// - Pre-sync proportional gain is (setting+1) times base proportional gain.
// - Post-sync integral gain keeps pre-sync value, or halves base when bit set.
// - Post-sync proportional gain keeps pre-sync value, or equals base when set.
// - Rate offset limit: off, 3.125, 6.25 or 12.5 percent.
// - Digital gain cap removes the N highest digital gain steps.
// - Front amplifier cap lowers the allowed combined gain ceiling stepwise.
// - Amplitude target code selects 24 to 42 dB; reset code is 3.
// - Priority bit picks which amplifier gets its gain lowered first.
// - Relative carrier sense on 6, 10 or 14 dB rise; code 0 disables.
// - Absolute carrier sense threshold signed around target; code 1000 disables.
// - Hysteresis field selects dead zone behaviour; reset is 2.
// - After a gain change skip 8, 16, 24 or 32 filter samples.
// - Freeze modes: none, on sync, analogue only, both.
// - Averaging 8 to 64 samples, or on-off boundary 4 to 16 dB.
// - Event 0 count split in high and low bytes, reset 0x87 and 0x6b.
// - Event 0 period is count times two to five times resolution.
// - Event 1 fires 4 to 48 slow periods after event 0; reset 7.
// - Powerdown resets to 1; writing 0 powers up, and starts calibration if the written calibration enable is 1.
// - Calibration enable permits calibration when 1; resets to 1.
`include "dgw_map.svh"

module dgw_config_bank (
   input logic clock,
   input logic rst_n,
   input logic [5:0] reg_addr,
   input logic reg_wr_en,
   input logic [7:0] reg_wr_data,
   output logic [7:0] reg_rd_data,
   input logic sync_found,
   output logic [3:0] integral_gain_half,
   output logic [2:0] proportional_gain_mult,
   output logic rate_comp_enable,
   output logic [2:0] rate_limit_32nds,
   output logic [1:0] digital_gain_excluded,
   output logic [2:0] front_amp_gain_cap,
   output logic [5:0] amplitude_target_db,
   output logic gain_reduction_priority,
   output logic relative_sense_enable,
   output logic [3:0] relative_sense_db,
   output logic absolute_sense_enable,
   output logic [5:0] absolute_sense_db,
   output logic [1:0] gain_hysteresis,
   output logic [5:0] settle_samples,
   output logic freeze_analog,
   output logic freeze_digital,
   output logic [6:0] averaging_samples,
   output logic [4:0] ook_boundary_db,
   output logic [15:0] wake_period_count,
   output logic [3:0] wake_resolution_shift,
   output logic [5:0] wake_second_delay,
   output logic slow_osc_powerdown,
   output logic slow_osc_cal_enable,
   output logic slow_osc_cal_start
);

   dgw_pkg::dgw_state_t st;
   dgw_pkg::dgw_state_t next_st;

   // Register writes, read-back and field decoding, all from the next values
   always_comb begin
      logic [47:0] target_lut;
      logic [47:0] evt1_lut;
      logic [1:0] code2;
      logic [2:0] code3;
      logic [3:0] abs_thr;
      target_lut = `DGW_TARGET_LUT;
      evt1_lut = `DGW_EVT1_LUT;
      code2 = 2'h0;
      code3 = 3'h0;
      abs_thr = 4'h0;
      next_st = st;
      next_st.slow_osc_cal_start = 1'b0;

      // Host writes; unused bits are masked so they read as zero
      if (reg_wr_en) begin
         unique case (reg_addr)
            `DGW_ADDR_BIT_SYNC: next_st.bit_sync_loop_config = reg_wr_data;
            `DGW_ADDR_GAIN_LIMITS: next_st.gain_control_limits = reg_wr_data;
            `DGW_ADDR_GAIN_PRIO: begin
               next_st.gain_priority_carrier_sense = reg_wr_data & `DGW_MASK_GAIN_PRIO;
            end
            `DGW_ADDR_GAIN_DYN: next_st.gain_loop_dynamics = reg_wr_data;
            `DGW_ADDR_EVT0_HIGH: next_st.wake_wake_period_count_high_byte = reg_wr_data;
            `DGW_ADDR_EVT0_LOW: next_st.wake_wake_period_count_low_byte = reg_wr_data;
            `DGW_ADDR_WAKE_CTRL: begin
               next_st.wake_timer_control = reg_wr_data & `DGW_MASK_WAKE_CTRL;
               // Power-up from powerdown launches calibration if permitted
               if (st.wake_timer_control[`DGW_F_OSC_PD] && !reg_wr_data[`DGW_F_OSC_PD] &&
                   reg_wr_data[`DGW_F_CAL_EN]) begin
                  next_st.slow_osc_cal_start = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // Read-back of the addressed register, zero for unmapped offsets
      unique case (reg_addr)
         `DGW_ADDR_BIT_SYNC: next_st.rd_data = next_st.bit_sync_loop_config;
         `DGW_ADDR_GAIN_LIMITS: next_st.rd_data = next_st.gain_control_limits;
         `DGW_ADDR_GAIN_PRIO: next_st.rd_data = next_st.gain_priority_carrier_sense;
         `DGW_ADDR_GAIN_DYN: next_st.rd_data = next_st.gain_loop_dynamics;
         `DGW_ADDR_EVT0_HIGH: next_st.rd_data = next_st.wake_wake_period_count_high_byte;
         `DGW_ADDR_EVT0_LOW: next_st.rd_data = next_st.wake_wake_period_count_low_byte;
         `DGW_ADDR_WAKE_CTRL: next_st.rd_data = next_st.wake_timer_control;
         default: next_st.rd_data = 8'h00;
      endcase

      // Clock recovery gains: integral in units of half the base integral gain, proportional in base units
      code2 = next_st.bit_sync_loop_config[`DGW_F_PRE_KI];
      if (sync_found && next_st.bit_sync_loop_config[`DGW_F_POST_KI]) begin
         next_st.integral_gain_half = 4'h1;
      end else begin
         next_st.integral_gain_half = {({1'b0, code2} + 3'h1), 1'b0};
      end
      code2 = next_st.bit_sync_loop_config[`DGW_F_PRE_KP];
      if (sync_found && next_st.bit_sync_loop_config[`DGW_F_POST_KP]) begin
         next_st.proportional_gain_mult = 3'h1;
      end else begin
         next_st.proportional_gain_mult = {1'b0, code2} + 3'h1;
      end

      // Data rate offset limit in 1/32 units: 1, 2 or 4
      code2 = next_st.bit_sync_loop_config[`DGW_F_RATE_LIMIT];
      next_st.rate_comp_enable = (code2 != 2'h0);
      next_st.rate_limit_32nds = (code2 == 2'h0) ? 3'h0 : 3'(3'h1 << (code2 - 2'h1));

      // Gain caps and amplitude target
      next_st.digital_gain_excluded = next_st.gain_control_limits[`DGW_F_DIG_CAP];
      next_st.front_amp_gain_cap = next_st.gain_control_limits[`DGW_F_FRONT_CAP];
      code3 = next_st.gain_control_limits[`DGW_F_TARGET];
      next_st.amplitude_target_db = target_lut[code3*6 +: 6];

      // Reduction priority and carrier sense thresholds
      next_st.gain_reduction_priority =
         next_st.gain_priority_carrier_sense[`DGW_F_PRIORITY];
      code2 = next_st.gain_priority_carrier_sense[`DGW_F_REL_THR];
      next_st.relative_sense_enable = (code2 != 2'h0);
      next_st.relative_sense_db = (code2 == 2'h0) ? 4'h0 :
         4'(`DGW_REL_BASE_DB + `DGW_REL_STEP_DB * {2'h0, code2});
      abs_thr = next_st.gain_priority_carrier_sense[`DGW_F_ABS_THR];
      next_st.absolute_sense_enable = (abs_thr != `DGW_ABS_THR_OFF);
      next_st.absolute_sense_db = 6'(next_st.amplitude_target_db +
         {{2{abs_thr[3]}}, abs_thr});

      // Gain loop dynamics
      next_st.gain_hysteresis = next_st.gain_loop_dynamics[`DGW_F_HYST];
      code2 = next_st.gain_loop_dynamics[`DGW_F_SETTLE];
      next_st.settle_samples = {({1'b0, code2} + 3'h1), 3'h0};
      code2 = next_st.gain_loop_dynamics[`DGW_F_FREEZE];
      next_st.freeze_analog = (code2 == `DGW_FREEZE_ANALOG) || (code2 == `DGW_FREEZE_BOTH) ||
         ((code2 == `DGW_FREEZE_ON_SYNC) && sync_found);
      next_st.freeze_digital = (code2 == `DGW_FREEZE_BOTH) ||
         ((code2 == `DGW_FREEZE_ON_SYNC) && sync_found);
      code2 = next_st.gain_loop_dynamics[`DGW_F_AVERAGE];
      next_st.averaging_samples = 7'(7'h08 << code2);
      next_st.ook_boundary_db = {({1'b0, code2} + 3'h1), 2'h0};

      // Wake timer settings
      next_st.wake_period_count = {next_st.wake_wake_period_count_high_byte,
         next_st.wake_wake_period_count_low_byte};
      code2 = next_st.wake_timer_control[`DGW_F_RES];
      next_st.wake_resolution_shift = {code2, 2'h0} + {2'h0, code2};
      code3 = next_st.wake_timer_control[`DGW_F_EVT1];
      next_st.wake_second_delay = evt1_lut[code3*6 +: 6];
      next_st.slow_osc_powerdown = next_st.wake_timer_control[`DGW_F_OSC_PD];
      next_st.slow_osc_cal_enable = next_st.wake_timer_control[`DGW_F_CAL_EN];
   end

   // State register with synchronous reset to the listed values
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         st <= '0;
         st.bit_sync_loop_config <= `DGW_RST_BIT_SYNC;
         st.gain_control_limits <= `DGW_RST_GAIN_LIMITS;
         st.gain_priority_carrier_sense <= `DGW_RST_GAIN_PRIO;
         st.gain_loop_dynamics <= `DGW_RST_GAIN_DYN;
         st.wake_wake_period_count_high_byte <= `DGW_RST_EVT0_HIGH;
         st.wake_wake_period_count_low_byte <= `DGW_RST_EVT0_LOW;
         st.wake_timer_control <= `DGW_RST_WAKE_CTRL;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops
   assign reg_rd_data = st.rd_data;
   assign integral_gain_half = st.integral_gain_half;
   assign proportional_gain_mult = st.proportional_gain_mult;
   assign rate_comp_enable = st.rate_comp_enable;
   assign rate_limit_32nds = st.rate_limit_32nds;
   assign digital_gain_excluded = st.digital_gain_excluded;
   assign front_amp_gain_cap = st.front_amp_gain_cap;
   assign amplitude_target_db = st.amplitude_target_db;
   assign gain_reduction_priority = st.gain_reduction_priority;
   assign relative_sense_enable = st.relative_sense_enable;
   assign relative_sense_db = st.relative_sense_db;
   assign absolute_sense_enable = st.absolute_sense_enable;
   assign absolute_sense_db = st.absolute_sense_db;
   assign gain_hysteresis = st.gain_hysteresis;
   assign settle_samples = st.settle_samples;
   assign freeze_analog = st.freeze_analog;
   assign freeze_digital = st.freeze_digital;
   assign averaging_samples = st.averaging_samples;
   assign ook_boundary_db = st.ook_boundary_db;
   assign wake_period_count = st.wake_period_count;
   assign wake_resolution_shift = st.wake_resolution_shift;
   assign wake_second_delay = st.wake_second_delay;
   assign slow_osc_powerdown = st.slow_osc_powerdown;
   assign slow_osc_cal_enable = st.slow_osc_cal_enable;
   assign slow_osc_cal_start = st.slow_osc_cal_start;

   // Checks on the decoded outputs against the stored fields
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_n);

   sequence s_write(logic [5:0] a);
      reg_wr_en && (reg_addr == a);
   endsequence

   sequence s_power_up;
      s_write(`DGW_ADDR_WAKE_CTRL) ##0 st.wake_timer_control[`DGW_F_OSC_PD]
         ##0 !reg_wr_data[`DGW_F_OSC_PD] ##0 reg_wr_data[`DGW_F_CAL_EN];
   endsequence

   // Decoded outputs are cleared in reset and valid from the second edge after it
   sequence s_settled;
      $past(rst_n);
   endsequence

   // Clock recovery gains and rate limit
   a_presync_ki: assert property (s_settled ##0 !$past(sync_found) |->
      integral_gain_half == {({1'b0, st.bit_sync_loop_config[`DGW_F_PRE_KI]} + 3'h1), 1'b0})
      else $error("Pre-sync integral gain wrong");

   a_presync_kp: assert property (s_settled ##0 !$past(sync_found) |->
      proportional_gain_mult == {1'b0, st.bit_sync_loop_config[`DGW_F_PRE_KP]} + 3'h1)
      else $error("Pre-sync proportional gain wrong");

   a_postsync_ki: assert property ($past(sync_found) &&
      st.bit_sync_loop_config[`DGW_F_POST_KI] |-> integral_gain_half == 4'h1)
      else $error("Post-sync integral gain not half base");

   a_postsync_kp: assert property ($past(sync_found) &&
      !st.bit_sync_loop_config[`DGW_F_POST_KP] |->
      proportional_gain_mult == {1'b0, st.bit_sync_loop_config[`DGW_F_PRE_KP]} + 3'h1)
      else $error("Post-sync proportional gain lost pre-sync value");

   a_rate_limit: assert property (s_settled |->
      rate_comp_enable == (st.bit_sync_loop_config[`DGW_F_RATE_LIMIT] != 2'h0) &&
      (st.bit_sync_loop_config[`DGW_F_RATE_LIMIT] != 2'h3 || rate_limit_32nds == 3'h4))
      else $error("Rate offset limit decode wrong");

   // Gain caps, target and carrier sense
   a_digital_cap: assert property (s_settled |->
      digital_gain_excluded == st.gain_control_limits[`DGW_F_DIG_CAP])
      else $error("Digital gain cap wrong");

   a_front_cap: assert property (s_settled |->
      front_amp_gain_cap == st.gain_control_limits[`DGW_F_FRONT_CAP])
      else $error("Front cap wrong");

   a_target_range: assert property (s_settled |->
      amplitude_target_db >= `DGW_TARGET_MIN &&
      amplitude_target_db <= `DGW_TARGET_MAX)
      else $error("Amplitude target out of range");

   a_priority_bit: assert property (s_settled |->
      gain_reduction_priority == st.gain_priority_carrier_sense[`DGW_F_PRIORITY])
      else $error("Priority bit wrong");

   a_rel_sense: assert property (s_settled |->
      relative_sense_enable == (st.gain_priority_carrier_sense[`DGW_F_REL_THR] != 2'h0))
      else $error("Relative sense enable wrong");

   a_abs_sense: assert property (s_settled |->
      absolute_sense_enable ==
      (st.gain_priority_carrier_sense[`DGW_F_ABS_THR] != `DGW_ABS_THR_OFF))
      else $error("Absolute sense enable wrong");

   a_abs_level: assert property (s_settled ##0
      st.gain_priority_carrier_sense[`DGW_F_ABS_THR] == 4'h0 |->
      absolute_sense_db == amplitude_target_db)
      else $error("Absolute level not at target");

   // Gain loop dynamics
   a_gain_hysteresis: assert property (s_settled |->
      gain_hysteresis == st.gain_loop_dynamics[`DGW_F_HYST])
      else $error("Hysteresis wrong");

   a_settle_count: assert property (s_settled |->
      settle_samples[2:0] == 3'h0 &&
      settle_samples[5:3] == {1'b0, st.gain_loop_dynamics[`DGW_F_SETTLE]} + 3'h1)
      else $error("Settle sample count wrong");

   a_freeze_sync: assert property ($past(sync_found) &&
      st.gain_loop_dynamics[`DGW_F_FREEZE] == `DGW_FREEZE_ON_SYNC |->
      freeze_analog && freeze_digital)
      else $error("Gain not frozen on sync");

   a_filter_len: assert property (s_settled |->
      $onehot(averaging_samples) && averaging_samples[2:0] == 3'h0 &&
      ook_boundary_db[4:2] == {1'b0, st.gain_loop_dynamics[`DGW_F_AVERAGE]} + 3'h1)
      else $error("Averaging or boundary wrong");

   // Wake timer and read-back
   a_wake_period_count_split: assert property (s_write(`DGW_ADDR_EVT0_LOW) |=>
      wake_period_count[7:0] == $past(reg_wr_data))
      else $error("Event 0 low byte not applied");

   a_period_join: assert property (s_settled |->
      wake_period_count == {st.wake_wake_period_count_high_byte, st.wake_wake_period_count_low_byte})
      else $error("Event 0 count not joined");

   a_res_shift: assert property (s_settled |->
      wake_resolution_shift == {2'h0, st.wake_timer_control[`DGW_F_RES]} * 4'h5)
      else $error("Resolution shift wrong");

   a_second_delay: assert property (s_settled ##0
      st.wake_timer_control[`DGW_F_EVT1] == 3'h7 |-> wake_second_delay == 6'h30)
      else $error("Event 1 delay wrong");

   a_cal_launch: assert property (s_power_up |=>
      slow_osc_cal_start && !slow_osc_powerdown ##1 !slow_osc_cal_start)
      else $error("Calibration not launched once on power-up");

   a_cal_gate: assert property (s_write(`DGW_ADDR_WAKE_CTRL) ##0
      !reg_wr_data[`DGW_F_CAL_EN] |=> !slow_osc_cal_start && !slow_osc_cal_enable)
      else $error("Calibration not barred");

   a_reg_write: assert property (s_write(`DGW_ADDR_GAIN_PRIO) |=>
      reg_rd_data == ($past(reg_wr_data) & `DGW_MASK_GAIN_PRIO))
      else $error("Priority register read-back wrong");

endmodule

// ===== dgw_map.svh
// Register map of the receive-path and wake timer configuration bank.
// Assumes a 6-bit register address and 8-bit data from the serial host port.
`ifndef DGW_MAP_SVH
`define DGW_MAP_SVH

// Register offsets
`define DGW_ADDR_BIT_SYNC 6'h1a
`define DGW_ADDR_GAIN_LIMITS 6'h1b
`define DGW_ADDR_GAIN_PRIO 6'h1c
`define DGW_ADDR_GAIN_DYN 6'h1d
`define DGW_ADDR_EVT0_HIGH 6'h1e
`define DGW_ADDR_EVT0_LOW 6'h1f
`define DGW_ADDR_WAKE_CTRL 6'h20

// Reset values
`define DGW_RST_BIT_SYNC 8'h6c
`define DGW_RST_GAIN_LIMITS 8'h03
`define DGW_RST_GAIN_PRIO 8'h40
`define DGW_RST_GAIN_DYN 8'h91
`define DGW_RST_EVT0_HIGH 8'h87
`define DGW_RST_EVT0_LOW 8'h6b
`define DGW_RST_WAKE_CTRL 8'hf8

// Implemented bits; the rest read as zero
`define DGW_MASK_GAIN_PRIO 8'h7f
`define DGW_MASK_WAKE_CTRL 8'hfb

// Bit sync loop fields
`define DGW_F_PRE_KI 7:6
`define DGW_F_PRE_KP 5:4
`define DGW_F_POST_KI 3
`define DGW_F_POST_KP 2
`define DGW_F_RATE_LIMIT 1:0
// Gain limit fields
`define DGW_F_DIG_CAP 7:6
`define DGW_F_FRONT_CAP 5:3
`define DGW_F_TARGET 2:0
// Priority and carrier sense fields
`define DGW_F_PRIORITY 6
`define DGW_F_REL_THR 5:4
`define DGW_F_ABS_THR 3:0
// Gain loop dynamics fields
`define DGW_F_HYST 7:6
`define DGW_F_SETTLE 5:4
`define DGW_F_FREEZE 3:2
`define DGW_F_AVERAGE 1:0
// Wake timer control fields
`define DGW_F_OSC_PD 7
`define DGW_F_EVT1 6:4
`define DGW_F_CAL_EN 3
`define DGW_F_RES 1:0

// Special codes
`define DGW_ABS_THR_OFF 4'h8
`define DGW_FREEZE_ON_SYNC 2'h1
`define DGW_FREEZE_ANALOG 2'h2
`define DGW_FREEZE_BOTH 2'h3

// Tables packed low entry first: target in dB, event 1 delay in slow periods
`define DGW_TARGET_LUT {6'h2a, 6'h28, 6'h26, 6'h24, 6'h21, 6'h1e, 6'h1b, 6'h18}
`define DGW_EVT1_LUT {6'h30, 6'h20, 6'h18, 6'h10, 6'h0c, 6'h08, 6'h06, 6'h04}
`define DGW_TARGET_MIN 6'h18
`define DGW_TARGET_MAX 6'h2a
`define DGW_REL_STEP_DB 4'h4
`define DGW_REL_BASE_DB 4'h2

`endif

// ===== dgw_pkg.sv
// Types of the receive-path and wake timer configuration bank.
// Assumes dgw_map.svh for all numeric constants.
package dgw_pkg;

   // Whole state of the bank, registers and decoded outputs
   typedef struct packed {
      logic [7:0] bit_sync_loop_config;
      logic [7:0] gain_control_limits;
      logic [7:0] gain_priority_carrier_sense;
      logic [7:0] gain_loop_dynamics;
      logic [7:0] wake_wake_period_count_high_byte;
      logic [7:0] wake_wake_period_count_low_byte;
      logic [7:0] wake_timer_control;
      logic [7:0] rd_data;
      logic [3:0] integral_gain_half;
      logic [2:0] proportional_gain_mult;
      logic rate_comp_enable;
      logic [2:0] rate_limit_32nds;
      logic [1:0] digital_gain_excluded;
      logic [2:0] front_amp_gain_cap;
      logic [5:0] amplitude_target_db;
      logic gain_reduction_priority;
      logic relative_sense_enable;
      logic [3:0] relative_sense_db;
      logic absolute_sense_enable;
      logic [5:0] absolute_sense_db;
      logic [1:0] gain_hysteresis;
      logic [5:0] settle_samples;
      logic freeze_analog;
      logic freeze_digital;
      logic [6:0] averaging_samples;
      logic [4:0] ook_boundary_db;
      logic [15:0] wake_period_count;
      logic [3:0] wake_resolution_shift;
      logic [5:0] wake_second_delay;
      logic slow_osc_powerdown;
      logic slow_osc_cal_enable;
      logic slow_osc_cal_start;
   } dgw_state_t;

endpackage

// ===== demod_gain_wakeup_config_tb.sv
// Self-checking bench for the receive-path gain and wake timer configuration bank.
// Assumes dgw_map.svh offsets; the bench drives the register port and sync level itself.
`include "dgw_map.svh"

module demod_gain_wakeup_config_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] reg_addr = 6'h00;
   logic reg_wr_en = 1'b0;
   logic [7:0] reg_wr_data = 8'h00;
   logic sync_found = 1'b0;
   logic [7:0] reg_rd_data;
   logic [3:0] integral_gain_half, relative_sense_db, wake_resolution_shift;
   logic [2:0] proportional_gain_mult, rate_limit_32nds, front_amp_gain_cap;
   logic [1:0] digital_gain_excluded, gain_hysteresis;
   logic [5:0] amplitude_target_db, absolute_sense_db, settle_samples, wake_second_delay;
   logic [6:0] averaging_samples;
   logic [4:0] ook_boundary_db;
   logic [15:0] wake_period_count;
   logic rate_comp_enable, gain_reduction_priority, relative_sense_enable;
   logic absolute_sense_enable, freeze_analog, freeze_digital;
   logic slow_osc_powerdown, slow_osc_cal_enable, slow_osc_cal_start;
   int bad_count = 0;
   int cmp_count = 0;
   int k;
   // Expected decode tables, low code first
   logic [7:0] target_tab [8] = '{8'h18, 8'h1b, 8'h1e, 8'h21, 8'h24, 8'h26, 8'h28, 8'h2a};
   logic [7:0] delay_tab [8] = '{8'h04, 8'h06, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h20, 8'h30};
   logic [7:0] limit_tab [4] = '{8'h00, 8'h01, 8'h02, 8'h04};
   logic [3:0] abs_code [4] = '{4'h8, 4'h9, 4'hf, 4'h7};
   logic [7:0] abs_db [4] = '{8'h00, 8'h1a, 8'h20, 8'h28};

   dgw_config_bank DUT (
      .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .sync_found(sync_found),
      .integral_gain_half(integral_gain_half), .proportional_gain_mult(proportional_gain_mult),
      .rate_comp_enable(rate_comp_enable), .rate_limit_32nds(rate_limit_32nds),
      .digital_gain_excluded(digital_gain_excluded), .front_amp_gain_cap(front_amp_gain_cap),
      .amplitude_target_db(amplitude_target_db),
      .gain_reduction_priority(gain_reduction_priority),
      .relative_sense_enable(relative_sense_enable), .relative_sense_db(relative_sense_db),
      .absolute_sense_enable(absolute_sense_enable), .absolute_sense_db(absolute_sense_db),
      .gain_hysteresis(gain_hysteresis), .settle_samples(settle_samples),
      .freeze_analog(freeze_analog), .freeze_digital(freeze_digital),
      .averaging_samples(averaging_samples), .ook_boundary_db(ook_boundary_db),
      .wake_period_count(wake_period_count), .wake_resolution_shift(wake_resolution_shift),
      .wake_second_delay(wake_second_delay), .slow_osc_powerdown(slow_osc_powerdown),
      .slow_osc_cal_enable(slow_osc_cal_enable), .slow_osc_cal_start(slow_osc_cal_start)
   );

   // 50 MHz clock
   always #10 clock = ~clock;

   // Compare one value and count the outcome
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Write held over one rising edge; strobe stays up so writes can run back to back
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wr_data = d;
      reg_wr_en = 1'b1;
      @(negedge clock);
   endtask

   // Idle one cycle with the strobe down
   task automatic tick;
      reg_wr_en = 1'b0;
      @(negedge clock);
   endtask

   // Registered read, one cycle after the address is set
   task automatic rd(input logic [5:0] a, input logic [7:0] exp);
      reg_wr_en = 1'b0;
      reg_addr = a;
      @(negedge clock);
      chk("reg_rd_data", reg_rd_data, exp);
   endtask

   // Hold reset low for four cycles
   task automatic do_reset;
      rst_n = 1'b0;
      repeat (4) @(negedge clock);
      rst_n = 1'b1;
   endtask

   // Reset values of every register and their decodes
   task automatic chk_reset;
      rd(`DGW_ADDR_BIT_SYNC, 8'h6c);
      rd(`DGW_ADDR_GAIN_LIMITS, 8'h03);
      rd(`DGW_ADDR_GAIN_PRIO, 8'h40);
      rd(`DGW_ADDR_GAIN_DYN, 8'h91);
      rd(`DGW_ADDR_EVT0_HIGH, 8'h87);
      rd(`DGW_ADDR_EVT0_LOW, 8'h6b);
      rd(`DGW_ADDR_WAKE_CTRL, 8'hf8);
      chk("integral_gain_half", integral_gain_half, 16'h4);
      chk("proportional_gain_mult", proportional_gain_mult, 16'h3);
      chk("amplitude_target_db", amplitude_target_db, 16'h21);
      chk("absolute_sense_db", absolute_sense_db, 16'h21);
      chk("settle_samples", settle_samples, 16'h10);
      chk("wake_period_count", wake_period_count, 16'h876b);
      chk("wake_second_delay", wake_second_delay, 16'h30);
      chk("slow_osc_powerdown", slow_osc_powerdown, 16'h1);
      chk("slow_osc_cal_enable", slow_osc_cal_enable, 16'h1);
   endtask

   // Print counts and verdict, then stop
   task automatic test_done;
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      do_reset();
      chk_reset();
      wr(6'h21, 8'h55);
      rd(6'h21, 8'h00);
      rd(6'h00, 8'h00);
      rd(`DGW_ADDR_WAKE_CTRL, 8'hf8);
      // Clock recovery gains before and after sync, rate limit codes
      for (k = 0; k < 4; k++) begin
         wr(`DGW_ADDR_BIT_SYNC, 8'(k * 8'h51 + 8'h0c));
         chk("integral_gain_half", integral_gain_half, 16'(2 * (k + 1)));
         chk("proportional_gain_mult", proportional_gain_mult, 16'(k + 1));
         chk("rate_comp_enable", rate_comp_enable, 16'(k != 0));
         chk("rate_limit_32nds", rate_limit_32nds, 16'(limit_tab[k]));
         sync_found = 1'b1;
         tick();
         chk("integral_gain_half", integral_gain_half, 16'h1);
         chk("proportional_gain_mult", proportional_gain_mult, 16'h1);
         wr(`DGW_ADDR_BIT_SYNC, 8'(k * 8'h51));
         chk("integral_gain_half", integral_gain_half, 16'(2 * (k + 1)));
         chk("proportional_gain_mult", proportional_gain_mult, 16'(k + 1));
         sync_found = 1'b0;
      end
      // Gain caps and amplitude target codes
      for (k = 0; k < 8; k++) begin
         wr(`DGW_ADDR_GAIN_LIMITS, 8'(((k % 4) << 6) | (k << 3) | k));
         chk("digital_gain_excluded", digital_gain_excluded, 16'(k % 4));
         chk("front_amp_gain_cap", front_amp_gain_cap, 16'(k));
         chk("amplitude_target_db", amplitude_target_db, 16'(target_tab[k]));
      end
      wr(`DGW_ADDR_GAIN_LIMITS, 8'h03);
      // Priority and carrier sense thresholds around a 33 dB target
      for (k = 0; k < 4; k++) begin
         wr(`DGW_ADDR_GAIN_PRIO, 8'(((k % 2) << 6) | (k << 4) | abs_code[k]));
         chk("gain_reduction_priority", gain_reduction_priority, 16'(k % 2));
         chk("relative_sense_enable", relative_sense_enable, 16'(k != 0));
         chk("absolute_sense_enable", absolute_sense_enable, 16'(k != 0));
         if (k != 0) begin
            chk("relative_sense_db", relative_sense_db, 16'(2 + 4 * k));
            chk("absolute_sense_db", absolute_sense_db, 16'(abs_db[k]));
         end
      end
      wr(`DGW_ADDR_GAIN_PRIO, 8'hff);
      rd(`DGW_ADDR_GAIN_PRIO, 8'h7f);
      // Hysteresis, settle count, freeze modes and averaging
      for (k = 0; k < 4; k++) begin
         wr(`DGW_ADDR_GAIN_DYN, 8'(k * 8'h55));
         chk("gain_hysteresis", gain_hysteresis, 16'(k));
         chk("settle_samples", settle_samples, 16'(8 * (k + 1)));
         chk("freeze_analog", freeze_analog, 16'(k >= 2));
         chk("freeze_digital", freeze_digital, 16'(k == 3));
         chk("averaging_samples", averaging_samples, 16'(8 << k));
         chk("ook_boundary_db", ook_boundary_db, 16'(4 * (k + 1)));
         if (k == 1) begin
            sync_found = 1'b1;
            tick();
            chk("freeze_digital", freeze_digital, 16'h1);
            chk("freeze_analog", freeze_analog, 16'h1);
            sync_found = 1'b0;
            tick();
            chk("freeze_analog", freeze_analog, 16'h0);
         end
      end
      // Event 0 bytes applied one at a time
      wr(`DGW_ADDR_EVT0_HIGH, 8'h12);
      wr(`DGW_ADDR_EVT0_LOW, 8'h34);
      chk("wake_period_count", wake_period_count, 16'h1234);
      wr(`DGW_ADDR_EVT0_HIGH, 8'hab);
      chk("wake_period_count", wake_period_count, 16'hab34);
      // Event 1 delay and resolution codes with the oscillator kept down
      for (k = 0; k < 8; k++) begin
         wr(`DGW_ADDR_WAKE_CTRL, 8'(8'h88 | (k << 4) | (k % 4)));
         chk("wake_second_delay", wake_second_delay, 16'(delay_tab[k]));
         chk("wake_resolution_shift", wake_resolution_shift, 16'(5 * (k % 4)));
         chk("slow_osc_cal_start", slow_osc_cal_start, 16'h0);
      end
      wr(`DGW_ADDR_WAKE_CTRL, 8'hff);
      rd(`DGW_ADDR_WAKE_CTRL, 8'hfb);
      // Power-up with calibration barred, then with it allowed, then already up
      wr(`DGW_ADDR_WAKE_CTRL, 8'h70);
      chk("slow_osc_cal_start", slow_osc_cal_start, 16'h0);
      chk("slow_osc_cal_enable", slow_osc_cal_enable, 16'h0);
      wr(`DGW_ADDR_WAKE_CTRL, 8'hf8);
      wr(`DGW_ADDR_WAKE_CTRL, 8'h78);
      chk("slow_osc_cal_start", slow_osc_cal_start, 16'h1);
      chk("slow_osc_powerdown", slow_osc_powerdown, 16'h0);
      tick();
      chk("slow_osc_cal_start", slow_osc_cal_start, 16'h0);
      wr(`DGW_ADDR_WAKE_CTRL, 8'h78);
      chk("slow_osc_cal_start", slow_osc_cal_start, 16'h0);
      tick();
      // Second reset in mid-run restores every register
      do_reset();
      chk_reset();
      test_done();
   end

   // Watchdog well beyond the 78 cycles the sequence needs
   initial begin
      #200000;
      bad_count++;
      test_done();
   end
endmodule
